// *** fopalu_core.sv ***
// fopalu_core: executes complement, decrement, decrement-skip and xor ops
// assumes: fetch unit presents one word per cycle with a valid strobe; the
// register file returns the addressed byte combinationally on file_rdata
// assumes: reset is synchronous and active high; the fetch unit keeps a
// file-reading word out of the cycle in which file_we is high
// Functional notes
// [RULE1] 0010 01df ffff complements file register
// [RULE2] d=0 writes accumulator, d=1 writes file
// [RULE3] 0000 11df ffff decrements file register
// [RULE4] 0010 11df ffff decrements, leaves status untouched
// [RULE5] zero result discards prefetched word, two cycles
// [RULE6] 1111 kkkk kkkk xors literal into accumulator
// [RULE7] 0001 10df ffff xors accumulator with file
// [RULE8] zero flag from result; one cycle each
`timescale 1ns/1ps
module fopalu_core (
  input  wire logic        clk,          // core clock
  input  wire logic        reset,        // synchronous, active high
  input  wire logic        instr_valid,  // instruction word present
  input  wire logic [11:0] instr,        // instruction word
  input  wire logic [7:0]  file_rdata,   // addressed file register value
  output logic [4:0]       file_addr,    // file register index
  output logic             file_we,      // one-cycle file write strobe
  output logic [7:0]       file_wdata,   // file write data
  output logic [7:0]       acc,          // accumulator
  output logic             zero_flag,    // zero status flag
  output logic             skip,         // pulse: prefetched word discarded
  output logic             busy          // level: executing a skip nop
);
  fopalu_pkg::fopalu_op_type op;        // decoded op
  logic                      dest;      // destination bit
  logic [4:0]                index;     // file index
  logic [7:0]                literal;   // immediate
  logic [7:0]                result;    // alu result
  logic                      touch_z;   // op updates zero flag
  logic                      exec;      // op executes this cycle
  logic [7:0]                acc_q;     // accumulator
  logic [7:0]                acc_d;     // next accumulator
  logic                      z_q;       // zero flag
  logic                      z_d;       // next zero flag
  logic                      we_q;      // file write strobe
  logic                      we_d;      // next write strobe
  logic [7:0]                wd_q;      // file write data
  logic [7:0]                wd_d;      // next write data
  logic [4:0]                fa_q;      // file write index
  logic [4:0]                fa_d;      // next write index
  logic                      sk_q;      // skip cycle in progress
  logic                      sk_d;      // next skip state

  // true when the result lands in the accumulator rather than the file
  function automatic logic writes_acc(input fopalu_pkg::fopalu_op_type o, input logic d);
    return (o == fopalu_pkg::FOPALU_XLIT) || (d == fopalu_pkg::DEST_ACC);
  endfunction

  // the file index comes straight from the word so rdata is ready this cycle
  fopalu_decode u_dec (
    .instr   (instr),
    .op      (op),
    .dest    (dest),
    .index   (index),
    .literal (literal)
  );

  // refuse package widths that the fixed port widths cannot carry
  if (fopalu_pkg::INSTR_W != 12 || fopalu_pkg::DATA_W != 8
      || fopalu_pkg::ADDR_W != 5) begin : g_width_check
    $error("package widths do not match the port widths");
  end

  // alu: compute result per operation
  // the zero test of the result is shared by every op that touches the flag
  always_comb begin
    result  = 8'h00;
    touch_z = 1'b0;
    case (op)
      fopalu_pkg::FOPALU_CMPL: begin
        result  = ~file_rdata;                    // see [RULE1]
        touch_z = 1'b1;
      end
      fopalu_pkg::FOPALU_DECR: begin
        result  = file_rdata - 8'h01;             // see [RULE3]
        touch_z = 1'b1;
      end
      fopalu_pkg::FOPALU_DSKZ: begin
        result  = file_rdata - 8'h01;             // flag untouched, see [RULE4]
      end
      fopalu_pkg::FOPALU_XLIT: begin
        result  = acc_q ^ literal;                // see [RULE6]
        touch_z = 1'b1;
      end
      fopalu_pkg::FOPALU_XFIL: begin
        result  = acc_q ^ file_rdata;             // see [RULE7]
        touch_z = 1'b1;
      end
      default: begin
        result  = 8'h00;                          // op outside subset
      end
    endcase
  end

  // next state: the word during a skip cycle is the discarded one
  always_comb begin
    exec  = instr_valid && !sk_q;                 // nop replaces it, see [RULE5]
    acc_d = acc_q;
    z_d   = z_q;
    we_d  = 1'b0;
    wd_d  = result;
    fa_d  = index;
    sk_d  = 1'b0;
    // unknown opcodes and idle cycles leave the accumulator and zero flag as they were
    if (exec && op != fopalu_pkg::FOPALU_NONE) begin
      if (touch_z) begin
        z_d = (result == 8'h00);                  // see [RULE8]
      end
      if (writes_acc(op, dest)) begin
        acc_d = result;                           // see [RULE2]
      end else begin
        we_d = 1'b1;                              // write back, see [RULE2]
      end
      if (op == fopalu_pkg::FOPALU_DSKZ && result == 8'h00) begin
        sk_d = 1'b1;                              // second cycle, see [RULE5]
      end
    end
  end

  // register all state
  // reset is synchronous, so outputs are clean from the first edge on
  always_ff @(posedge clk) begin
    if (reset) begin
      acc_q <= fopalu_pkg::ACC_RESET;
      z_q   <= fopalu_pkg::ZERO_RESET;
      we_q  <= 1'b0;
      wd_q  <= 8'h00;
      fa_q  <= 5'h00;
      sk_q  <= 1'b0;
    end else begin
      acc_q <= acc_d;
      z_q   <= z_d;
      we_q  <= we_d;
      wd_q  <= wd_d;
      fa_q  <= fa_d;
      sk_q  <= sk_d;
    end
  end

  // file_addr for the read is the live index; the write uses the registered one
  // hazard: a word that reads a file register in a write cycle sees the write
  // index instead, so the fetch side must not place one there
  assign file_addr  = we_q ? fa_q : index;
  assign file_we    = we_q;
  assign file_wdata = wd_q;
  assign acc        = acc_q;
  assign zero_flag  = z_q;
  assign skip       = sk_q;
  assign busy       = sk_q;

  // checks: each result is seen one cycle after the word is taken
  a_cmpl_result: assert property (@(posedge clk) disable iff (reset) // see [RULE1]
    (exec && op == fopalu_pkg::FOPALU_CMPL && !dest)
    |=> acc == ~$past(file_rdata))
    else $error("complement result wrong");
  a_cmpl_file: assert property (@(posedge clk) disable iff (reset) // see [RULE1]
    (exec && op == fopalu_pkg::FOPALU_CMPL && dest)
    |=> file_we && file_wdata == ~$past(file_rdata))
    else $error("complement write-back wrong");
  a_dest_file: assert property (@(posedge clk) disable iff (reset) // see [RULE2]
    (exec && dest && op inside {fopalu_pkg::FOPALU_CMPL, fopalu_pkg::FOPALU_DECR,
     fopalu_pkg::FOPALU_DSKZ, fopalu_pkg::FOPALU_XFIL})
    |=> file_we && $stable(acc))
    else $error("file destination not honoured");
  a_dest_acc: assert property (@(posedge clk) disable iff (reset) // see [RULE2]
    (exec && op != fopalu_pkg::FOPALU_NONE && writes_acc(op, dest))
    |=> !file_we)
    else $error("accumulator destination wrote the file");
  a_dec_result: assert property (@(posedge clk) disable iff (reset) // see [RULE3]
    (exec && op == fopalu_pkg::FOPALU_DECR && dest)
    |=> file_wdata == $past(file_rdata) - 8'h01)
    else $error("decrement result wrong");
  a_dec_acc: assert property (@(posedge clk) disable iff (reset) // see [RULE3]
    (exec && op == fopalu_pkg::FOPALU_DECR && !dest)
    |=> acc == $past(file_rdata) - 8'h01)
    else $error("decrement into accumulator wrong");
  a_dskz_flag: assert property (@(posedge clk) disable iff (reset) // see [RULE4]
    (exec && op == fopalu_pkg::FOPALU_DSKZ) |=> $stable(zero_flag))
    else $error("decrement-skip changed zero flag");
  a_dskz_result: assert property (@(posedge clk) disable iff (reset) // see [RULE4]
    (exec && op == fopalu_pkg::FOPALU_DSKZ)
    |=> (file_we ? file_wdata : acc) == $past(file_rdata) - 8'h01)
    else $error("decrement-skip result wrong");
  a_skip_zero: assert property (@(posedge clk) disable iff (reset) // see [RULE5]
    (exec && op == fopalu_pkg::FOPALU_DSKZ && file_rdata == 8'h01)
    |=> skip ##1 !skip)
    else $error("skip not taken for one cycle");
  a_skip_nonzero: assert property (@(posedge clk) disable iff (reset) // see [RULE5]
    (exec && op == fopalu_pkg::FOPALU_DSKZ && file_rdata != 8'h01)
    |=> !skip)
    else $error("skip taken on a nonzero result");
  a_skip_drop: assert property (@(posedge clk) disable iff (reset) // see [RULE5]
    skip |=> !file_we && $stable(acc) && $stable(zero_flag))
    else $error("discarded word changed state");
  a_skip_once: assert property (@(posedge clk) disable iff (reset) // see [RULE5]
    skip |=> !skip && !busy)
    else $error("skip held longer than one cycle");
  a_xlit_acc: assert property (@(posedge clk) disable iff (reset) // see [RULE6]
    (exec && op == fopalu_pkg::FOPALU_XLIT)
    |=> acc == ($past(acc) ^ $past(instr[7:0])) && !file_we)
    else $error("literal xor wrong");
  a_xfil_acc: assert property (@(posedge clk) disable iff (reset) // see [RULE7]
    (exec && op == fopalu_pkg::FOPALU_XFIL && !dest)
    |=> acc == ($past(acc) ^ $past(file_rdata)))
    else $error("file xor wrong");
  a_xfil_file: assert property (@(posedge clk) disable iff (reset) // see [RULE7]
    (exec && op == fopalu_pkg::FOPALU_XFIL && dest)
    |=> file_wdata == ($past(acc) ^ $past(file_rdata)))
    else $error("file xor write-back wrong");
  a_zero_flag: assert property (@(posedge clk) disable iff (reset) // see [RULE8]
    (exec && touch_z) |=> zero_flag == ($past(result) == 8'h00))
    else $error("zero flag wrong");

  // scenarios that the random stream should reach
  c_skip: cover property (@(posedge clk) disable iff (reset) skip);
  c_write: cover property (@(posedge clk) disable iff (reset) file_we);
  c_zero: cover property (@(posedge clk) disable iff (reset) $rose(zero_flag));
  c_skip_write: cover property (@(posedge clk) disable iff (reset) skip && file_we);
  c_xlit_taken: cover property (@(posedge clk) disable iff (reset)
    exec && op == fopalu_pkg::FOPALU_XLIT);
endmodule // fopalu_core

// *** fopalu_decode.sv ***
// fopalu_decode: combinational decode of one instruction word
// assumes: word is stable while valid; fields defined in fopalu_pkg
`timescale 1ns/1ps
module fopalu_decode (
  input  wire logic [11:0]             instr,    // instruction word
  output fopalu_pkg::fopalu_op_type    op,       // decoded operation
  output logic                         dest,     // destination bit
  output logic [4:0]                   index,    // file register index
  output logic [7:0]                   literal   // immediate byte
);
  // pick the operation from the opcode fields
  always_comb begin
    dest    = instr[fopalu_pkg::DEST_BIT];
    index   = instr[4:0];
    literal = instr[7:0];
    if (instr[fopalu_pkg::OP4_HI -: 4] == fopalu_pkg::OP_XOR_LIT) begin
      op = fopalu_pkg::FOPALU_XLIT;                                 // see [RULE6]
    end else begin
      case (instr[fopalu_pkg::OP6_HI -: 6])
        fopalu_pkg::OP_COMPLEMENT: op = fopalu_pkg::FOPALU_CMPL;    // see [RULE1]
        fopalu_pkg::OP_DECREMENT:  op = fopalu_pkg::FOPALU_DECR;    // see [RULE3]
        fopalu_pkg::OP_DEC_SKIP:   op = fopalu_pkg::FOPALU_DSKZ;    // see [RULE4]
        fopalu_pkg::OP_XOR_FILE:   op = fopalu_pkg::FOPALU_XFIL;    // see [RULE7]
        default:                   op = fopalu_pkg::FOPALU_NONE;    // not in this subset
      endcase
    end
  end
endmodule // fopalu_decode

// *** fopalu_pkg.sv ***
// fopalu_pkg: constants for the file-operand alu subset
// assumes: 12-bit instruction words, 8-bit data, 32 file registers
package fopalu_pkg;
  localparam int INSTR_W    = 12;                 // instruction width
  localparam int DATA_W     = 8;                  // data width
  localparam int ADDR_W     = 5;                  // file index width
  localparam int DEST_BIT   = 5;                  // destination bit position
  localparam int OP6_HI     = 11;                 // six-bit opcode top
  localparam int OP4_HI     = 11;                 // four-bit opcode top
  localparam logic [5:0] OP_COMPLEMENT = 6'h09;   // 0010 01
  localparam logic [5:0] OP_DECREMENT  = 6'h03;   // 0000 11
  localparam logic [5:0] OP_DEC_SKIP   = 6'h0b;   // 0010 11
  localparam logic [5:0] OP_XOR_FILE   = 6'h06;   // 0001 10
  localparam logic [3:0] OP_XOR_LIT    = 4'hf;    // 1111
  localparam logic       DEST_ACC      = 1'b0;    // result to accumulator
  localparam logic       DEST_FILE     = 1'b1;    // result back to file
  localparam logic [7:0] ACC_RESET     = 8'h00;   // accumulator reset value
  localparam logic       ZERO_RESET    = 1'b0;    // zero flag reset value
  // decoded operation
  typedef enum logic [5:0] {
    FOPALU_NONE = 6'b000001,
    FOPALU_CMPL = 6'b000010,
    FOPALU_DECR = 6'b000100,
    FOPALU_DSKZ = 6'b001000,
    FOPALU_XLIT = 6'b010000,
    FOPALU_XFIL = 6'b100000
  } fopalu_op_type;
endpackage

// *** fopalu_regfile.sv ***
// fopalu_regfile: behavioural file register array facing the core
// assumes: read is combinational from the index, write on a rising clk
`timescale 1ns/1ps
module fopalu_regfile (
  input  wire logic       clk,         // core clock
  input  wire logic [4:0] file_addr,   // index from the core
  input  wire logic       file_we,     // write strobe
  input  wire logic [7:0] file_wdata,  // write data
  output logic      [7:0] file_rdata   // addressed value
);
  logic [7:0] mem [32];  // contents, loaded by the bench at time zero
  // read follows the index with no delay
  assign file_rdata = mem[file_addr];
  // store on a write pulse
  always @(posedge clk) begin
    if (file_we) begin
      mem[file_addr] <= file_wdata;
    end
  end
endmodule // fopalu_regfile

// *** test_file_op_alu_subset.sv ***
// test_file_op_alu_subset: random instruction stream checked by a scoreboard
// assumes: fopalu_pkg, fopalu_core and fopalu_regfile are compiled first
`timescale 1ns/1ps
module test_file_op_alu_subset;
  typedef struct packed {
    logic [7:0] acc;
    logic       zero;
    logic       we;
    logic [7:0] wdata;
    logic [4:0] addr;
    logic       skip;
  } fopalu_exp_type;
  logic        clk, reset, instr_valid, file_we, zero_flag, skip, busy;
  logic [11:0] instr, w;
  logic [7:0]  file_rdata, file_wdata, acc, m_acc;
  logic [4:0]  file_addr;
  logic [7:0]  regs [32];  // model of the file contents
  logic        m_zero, m_skip, m_we;  // model flag, refusal, write pending
  int          fail_count, n_compared, k;
  fopalu_exp_type exp_q [$];  // expected results, oldest first
  logic [11:0] tmpl [6] = '{12'h240, 12'h0c0, 12'h2c0, 12'hf00, 12'h180, 12'h000};
  fopalu_core i_dut (.clk(clk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
    .file_rdata(file_rdata), .file_addr(file_addr), .file_we(file_we),
    .file_wdata(file_wdata), .acc(acc), .zero_flag(zero_flag), .skip(skip), .busy(busy));
  fopalu_regfile i_rf (.clk(clk), .file_addr(file_addr), .file_we(file_we),
    .file_wdata(file_wdata), .file_rdata(file_rdata));
  // clock of 10 ns
  always #5 clk = ~clk;
  // present one word at the falling edge and note its expected result
  task automatic drive(input logic v, input logic [11:0] wd);
    fopalu_exp_type e;
    logic [7:0] f, r;
    logic lit;
    e = '0;
    e.addr = wd[4:0];  // file_addr shows this index, or the same word's write index
    f = regs[wd[4:0]];
    r = 8'h00;
    lit = wd[11:8] == fopalu_pkg::OP_XOR_LIT;
    if (v && !m_skip && (lit || wd[11:6] inside {fopalu_pkg::OP_COMPLEMENT,
        fopalu_pkg::OP_DECREMENT, fopalu_pkg::OP_DEC_SKIP, fopalu_pkg::OP_XOR_FILE})) begin
      case (wd[11:6])
        fopalu_pkg::OP_COMPLEMENT: r = ~f;
        fopalu_pkg::OP_DECREMENT, fopalu_pkg::OP_DEC_SKIP: r = f - 8'h01;
        fopalu_pkg::OP_XOR_FILE: r = m_acc ^ f;
        default: r = m_acc ^ wd[7:0];
      endcase
      if (wd[11:6] != fopalu_pkg::OP_DEC_SKIP) m_zero = r == 8'h00;
      if (!lit && wd[fopalu_pkg::DEST_BIT] == fopalu_pkg::DEST_FILE) begin
        regs[wd[4:0]] = r;
        e.we = 1'b1;
        e.wdata = r;
        e.addr = wd[4:0];
      end else m_acc = r;
      e.skip = wd[11:6] == fopalu_pkg::OP_DEC_SKIP && r == 8'h00;
    end
    e.acc = m_acc;
    e.zero = m_zero;
    m_skip = e.skip;
    m_we = e.we;
    instr_valid = v;
    instr = wd;
    exp_q.push_back(e);
  endtask
  // compare outputs with the oldest note
  task automatic check(input fopalu_exp_type e);
    logic ok;
    ok = acc === e.acc && zero_flag === e.zero && file_we === e.we;
    ok = ok && skip === e.skip && busy === e.skip;
    ok = ok && file_addr === e.addr;
    if (e.we) ok = ok && file_wdata === e.wdata;
    n_compared++;
    if (!ok) begin
      fail_count++;
      $display("mismatch at %0t: acc %h zero %b we %b skip %b", $time, acc, zero_flag,
        file_we, skip);
    end
  endtask
  // watcher: results settle just after each rising edge
  always @(posedge clk) begin
    #2;
    if (exp_q.size() > 0) check(exp_q.pop_front());
  end
  // report counts and verdict
  task automatic finish_test();
    if (exp_q.size() > 0) fail_count++;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    instr_valid = 1'b0;
    instr = 12'h000;
    void'($urandom(32'h27e0));
    for (int i = 0; i < 32; i++) begin
      regs[i] = 8'($urandom_range(2, 0));
      i_rf.mem[i] = regs[i];
    end
    m_acc = fopalu_pkg::ACC_RESET;
    m_zero = fopalu_pkg::ZERO_RESET;
    m_skip = 1'b0;
    m_we = 1'b0;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    for (int n = 0; n < 600; n++) begin
      @(negedge clk);
      k = m_we ? 3 : int'($urandom_range(6, 0));  // no file read in a write cycle
      w = tmpl[k % 6] | (12'($urandom) & (k == 3 ? 12'h0ff : 12'h03f));
      drive(k != 6, w);
    end
    repeat (3) @(negedge clk);
    finish_test();
  end
endmodule // test_file_op_alu_subset
